// [pkg/ddcm_regs.vh]
// Contract
// - Path B quarter-rate mix enable, complex only
// - Path A swap emits Q before I
// - Path A Q-delay pairs I[n] with Q[n+1]
// - Path A quarter-rate mixer phase inversion
// - Path B swap emits Q before I
// - Path B Q-delay pairs I[n] with Q[n+1]
// - Path B quarter-rate mixer phase inversion
// - Path A 32-bit frequency word, LSB first
// - Path B 32-bit frequency word, LSB first
// - Real mode forces both frequency words zero
// - One real-output bit selects real or complex
// - Reload bit toggle resets phase, loads word
`ifndef DDCM_REGS_VH
`define DDCM_REGS_VH

// Register indices; byte address is four times the index
`define DDCM_IDX_DEC_CFG    6'h25
`define DDCM_IDX_MIX_CTRL   6'h26
`define DDCM_IDX_ORDER_A    6'h27
`define DDCM_IDX_FREQ_A0    6'h2a
`define DDCM_IDX_FREQ_A1    6'h2b
`define DDCM_IDX_FREQ_A2    6'h2c
`define DDCM_IDX_FREQ_A3    6'h2d
`define DDCM_IDX_ORDER_B    6'h2e
`define DDCM_IDX_FREQ_B0    6'h31
`define DDCM_IDX_FREQ_B1    6'h32
`define DDCM_IDX_FREQ_B2    6'h33
`define DDCM_IDX_FREQ_B3    6'h34
`define DDCM_IDX_STATUS     6'h35

// Field positions
`define DDCM_BIT_REAL_OUT   3
`define DDCM_BIT_RELOAD_A   5
`define DDCM_BIT_QMIX_A     4
`define DDCM_BIT_RELOAD_B   1
`define DDCM_BIT_QMIX_B     0
`define DDCM_BIT_SWAP       4
`define DDCM_BIT_QDEL       3
`define DDCM_BIT_PHASE_INV  2

// Writable bit masks; reserved bits stay zero
`define DDCM_MASK_DEC_CFG   8'hf9
`define DDCM_MASK_MIX_CTRL  8'hff
`define DDCM_MASK_ORDER     8'h1c
`define DDCM_MASK_FREQ      8'hff

// Reset values
`define DDCM_RST_BYTE       8'h00

// AXI responses
`define DDCM_RESP_OKAY      2'b00
`define DDCM_RESP_SLVERR    2'b10

`endif

// [verilog/ddcm_path.v]
`include "ddcm_regs.vh"
`default_nettype none

module ddcm_path #(
    parameter DW = 16
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          sample_valid,
    input  wire [DW-1:0] sample,
    input  wire          real_mode,
    input  wire          qmix_en,
    input  wire          phase_inv,
    input  wire          swap,
    input  wire          qdel,
    input  wire [31:0]   freq_word,
    input  wire          reload_tgl,
    output reg           out_valid_q,
    output reg  [DW-1:0] out_data_q,
    output reg           out_is_q_q,
    output reg  [31:0]   phase_q
);

    reg  [31:0]   step_q;
    reg           tgl_q;
    reg  [1:0]    quad_q;
    reg  [DW-1:0] i_prev_q;
    reg           pend_q;
    reg  [DW-1:0] second_q;
    reg           second_is_q_q;
    reg  [DW-1:0] mix_i;
    reg  [DW-1:0] mix_q;
    wire          reload;
    wire [DW-1:0] pair_i;
    wire [DW-1:0] pair_q;

    // Negation saturates so full-scale negative cannot wrap to itself
    function [DW-1:0] neg_sat;
        input [DW-1:0] v;
        begin
            if (v == {1'b1, {(DW-1){1'b0}}})
                neg_sat = {1'b0, {(DW-1){1'b1}}};
            else
                neg_sat = ~v + {{(DW-1){1'b0}}, 1'b1};
        end
    endfunction

    assign reload = reload_tgl ^ tgl_q;

    // Quarter-rate mixing walks 1, -j, -1, +j; inversion conjugates
    always @* begin
        mix_i = sample;
        mix_q = {DW{1'b0}};
        if (qmix_en && !real_mode) begin
            case (quad_q)
                2'd0: begin
                    mix_i = sample;
                end
                2'd1: begin
                    mix_i = {DW{1'b0}};
                    mix_q = neg_sat(sample);
                end
                2'd2: begin
                    mix_i = neg_sat(sample);
                end
                default: begin
                    mix_i = {DW{1'b0}};
                    mix_q = sample;
                end
            endcase
            if (phase_inv)
                mix_q = neg_sat(mix_q);
        end
    end

    // Delayed pairing holds I back one sample against the current Q
    assign pair_i = qdel ? i_prev_q : mix_i;
    assign pair_q = mix_q;

    // Oscillator phase and frequency load; real mode adds nothing
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tgl_q    <= 1'b0;
            phase_q  <= 32'h0000_0000;
            step_q   <= 32'h0000_0000;
            quad_q   <= 2'b00;
            i_prev_q <= {DW{1'b0}};
        end else begin
            tgl_q <= reload_tgl;
            if (reload) begin
                phase_q <= 32'h0000_0000;
                step_q  <= real_mode ? 32'h0000_0000 : freq_word;
                quad_q  <= 2'b00;
            end else if (sample_valid) begin
                phase_q  <= real_mode ? phase_q : phase_q + step_q;
                quad_q   <= quad_q + 2'b01;
                i_prev_q <= mix_i;
            end
        end
    end

    // Two words per sample; input must be spaced two cycles or more
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid_q   <= 1'b0;
            out_data_q    <= {DW{1'b0}};
            out_is_q_q    <= 1'b0;
            pend_q        <= 1'b0;
            second_q      <= {DW{1'b0}};
            second_is_q_q <= 1'b0;
        end else if (sample_valid) begin
            out_valid_q   <= 1'b1;
            out_data_q    <= swap ? pair_q : pair_i;
            out_is_q_q    <= swap;
            second_q      <= swap ? pair_i : pair_q;
            second_is_q_q <= ~swap;
            pend_q        <= 1'b1;
        end else if (pend_q) begin
            out_valid_q <= 1'b1;
            out_data_q  <= second_q;
            out_is_q_q  <= second_is_q_q;
            pend_q      <= 1'b0;
        end else begin
            out_valid_q <= 1'b0;
        end
    end

endmodule // ddcm_path

`default_nettype wire

// [verilog/ddcm_top.v]
// Chosen here: the AXI4-Lite interface to the registers.
`include "ddcm_regs.vh"
`default_nettype none

module ddcm_top #(
    parameter DW = 16,
    parameter AW = 8
) (
    input  wire          mclk,
    input  wire          sys_rst,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          adc_valid,
    input  wire [DW-1:0] adc_a,
    input  wire [DW-1:0] adc_b,
    output wire          out_valid_a,
    output wire [DW-1:0] out_data_a,
    output wire          out_is_q_a,
    output wire [31:0]   osc_phase_a,
    output wire          out_valid_b,
    output wire [DW-1:0] out_data_b,
    output wire          out_is_q_b,
    output wire [31:0]   osc_phase_b
);

    localparam NSLOT   = 13;
    localparam NWR     = 12;
    localparam [3:0] S_DEC   = 4'd0;
    localparam [3:0] S_MIX   = 4'd1;
    localparam [3:0] S_ORD_A = 4'd2;
    localparam [3:0] S_ORD_B = 4'd7;
    localparam [3:0] S_STAT  = 4'd12;
    localparam [3:0] S_NONE  = 4'd15;

    reg  [7:0]    cfg_q [0:NWR-1];
    reg  [AW-1:0] waddr_q;
    reg  [7:0]    wdata_q;
    reg           wstrb0_q;
    reg           aw_got_q;
    reg           w_got_q;
    reg           aw_got_d;
    reg           w_got_d;
    reg           bvalid_d;
    reg           rvalid_d;
    reg           do_wr;
    reg  [7:0]    rd_byte;
    wire [3:0]    wr_slot;
    wire [3:0]    rd_slot;
    wire          real_mode;
    wire [31:0]   freq_a;
    wire [31:0]   freq_b;
    wire [7:0]    status;
    integer       k;

    // Address to slot; shared by the read and write decoders
    function [3:0] ddcm_slot;
        input [AW-1:0] a;
        begin
            case (a[7:2])
                `DDCM_IDX_DEC_CFG:  ddcm_slot = 4'd0;
                `DDCM_IDX_MIX_CTRL: ddcm_slot = 4'd1;
                `DDCM_IDX_ORDER_A:  ddcm_slot = 4'd2;
                `DDCM_IDX_FREQ_A0:  ddcm_slot = 4'd3;
                `DDCM_IDX_FREQ_A1:  ddcm_slot = 4'd4;
                `DDCM_IDX_FREQ_A2:  ddcm_slot = 4'd5;
                `DDCM_IDX_FREQ_A3:  ddcm_slot = 4'd6;
                `DDCM_IDX_ORDER_B:  ddcm_slot = 4'd7;
                `DDCM_IDX_FREQ_B0:  ddcm_slot = 4'd8;
                `DDCM_IDX_FREQ_B1:  ddcm_slot = 4'd9;
                `DDCM_IDX_FREQ_B2:  ddcm_slot = 4'd10;
                `DDCM_IDX_FREQ_B3:  ddcm_slot = 4'd11;
                `DDCM_IDX_STATUS:   ddcm_slot = S_STAT;
                default:            ddcm_slot = S_NONE;
            endcase
        end
    endfunction

    // Writable bits per slot; reserved bits never store
    function [7:0] ddcm_mask;
        input [3:0] s;
        begin
            case (s)
                S_DEC:   ddcm_mask = `DDCM_MASK_DEC_CFG;
                S_MIX:   ddcm_mask = `DDCM_MASK_MIX_CTRL;
                S_ORD_A: ddcm_mask = `DDCM_MASK_ORDER;
                S_ORD_B: ddcm_mask = `DDCM_MASK_ORDER;
                default: ddcm_mask = `DDCM_MASK_FREQ;
            endcase
        end
    endfunction

    function is_freq;
        input [3:0] s;
        begin
            is_freq = (s >= 4'd3 && s <= 4'd6) || (s >= 4'd8 && s <= 4'd11);
        end
    endfunction

    assign wr_slot   = ddcm_slot(waddr_q);
    assign rd_slot   = ddcm_slot(s_axi_araddr);
    assign real_mode = cfg_q[S_DEC][`DDCM_BIT_REAL_OUT];
    assign freq_a    = {cfg_q[6], cfg_q[5], cfg_q[4], cfg_q[3]};
    assign freq_b    = {cfg_q[11], cfg_q[10], cfg_q[9], cfg_q[8]};
    assign status    = {osc_phase_a[31:28], osc_phase_b[31:28]};

    // Write channel bookkeeping; address and data may come in any order
    always @* begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        bvalid_d = s_axi_bvalid;
        do_wr    = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
            aw_got_d = 1'b1;
        if (s_axi_wvalid && s_axi_wready)
            w_got_d = 1'b1;
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        if (aw_got_q && w_got_q && !s_axi_bvalid) begin
            do_wr    = 1'b1;
            bvalid_d = 1'b1;
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
        end
    end

    // Write handshake registers; ready drops while a write is held
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            waddr_q       <= {AW{1'b0}};
            wdata_q       <= `DDCM_RST_BYTE;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DDCM_RESP_OKAY;
        end else begin
            aw_got_q      <= aw_got_d;
            w_got_q       <= w_got_d;
            s_axi_awready <= ~aw_got_d & ~bvalid_d;
            s_axi_wready  <= ~w_got_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            if (s_axi_awvalid && s_axi_awready)
                waddr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (do_wr)
                s_axi_bresp <= (wr_slot == S_NONE) ? `DDCM_RESP_SLVERR : `DDCM_RESP_OKAY;
        end
    end

    // Register bank; real mode holds the frequency bytes at zero
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (k = 0; k < NWR; k = k + 1)
                cfg_q[k] <= `DDCM_RST_BYTE;
        end else begin
            for (k = 0; k < NWR; k = k + 1) begin
                if (real_mode && is_freq(k[3:0]))
                    cfg_q[k] <= `DDCM_RST_BYTE;
                else if (do_wr && wstrb0_q && wr_slot == k[3:0])
                    cfg_q[k] <= wdata_q & ddcm_mask(k[3:0]);
            end
        end
    end

    // Read mux; only the low byte carries data
    always @* begin
        rd_byte = `DDCM_RST_BYTE;
        if (rd_slot == S_STAT)
            rd_byte = status;
        else if (rd_slot < S_STAT)
            rd_byte = cfg_q[rd_slot];
    end

    always @* begin
        rvalid_d = s_axi_rvalid;
        if (s_axi_rvalid && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
            rvalid_d = 1'b1;
    end

    // Read channel answers one cycle after the address is taken
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DDCM_RESP_OKAY;
        end else begin
            s_axi_rvalid  <= rvalid_d;
            s_axi_arready <= ~rvalid_d & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= (rd_slot == S_NONE) ? `DDCM_RESP_SLVERR : `DDCM_RESP_OKAY;
            end
        end
    end

    // Path A mixer and output stage
    ddcm_path #(
        .DW (DW)
    ) u_path_a (
        .clk          (mclk),
        .rst          (sys_rst),
        .sample_valid (adc_valid),
        .sample       (adc_a),
        .real_mode    (real_mode),
        .qmix_en      (cfg_q[S_MIX][`DDCM_BIT_QMIX_A]),
        .phase_inv    (cfg_q[S_ORD_A][`DDCM_BIT_PHASE_INV]),
        .swap         (cfg_q[S_ORD_A][`DDCM_BIT_SWAP]),
        .qdel         (cfg_q[S_ORD_A][`DDCM_BIT_QDEL]),
        .freq_word    (freq_a),
        .reload_tgl   (cfg_q[S_MIX][`DDCM_BIT_RELOAD_A]),
        .out_valid_q  (out_valid_a),
        .out_data_q   (out_data_a),
        .out_is_q_q   (out_is_q_a),
        .phase_q      (osc_phase_a)
    );

    // Path B mixer and output stage
    ddcm_path #(
        .DW (DW)
    ) u_path_b (
        .clk          (mclk),
        .rst          (sys_rst),
        .sample_valid (adc_valid),
        .sample       (adc_b),
        .real_mode    (real_mode),
        .qmix_en      (cfg_q[S_MIX][`DDCM_BIT_QMIX_B]),
        .phase_inv    (cfg_q[S_ORD_B][`DDCM_BIT_PHASE_INV]),
        .swap         (cfg_q[S_ORD_B][`DDCM_BIT_SWAP]),
        .qdel         (cfg_q[S_ORD_B][`DDCM_BIT_QDEL]),
        .freq_word    (freq_b),
        .reload_tgl   (cfg_q[S_MIX][`DDCM_BIT_RELOAD_B]),
        .out_valid_q  (out_valid_b),
        .out_data_q   (out_data_b),
        .out_is_q_q   (out_is_q_b),
        .phase_q      (osc_phase_b)
    );

endmodule // ddcm_top

`default_nettype wire

// [test/ddcm_checker.sv]
`include "ddcm_regs.vh"
`default_nettype none
module ddcm_checker #(
    parameter DW = 16,
    parameter AW = 8
) (
    input wire logic          mclk,
    input wire logic          sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic [31:0]   s_axi_wdata,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          adc_valid,
    input wire logic          out_valid_a,
    input wire logic          out_is_q_a,
    input wire logic          out_valid_b,
    input wire logic [DW-1:0] out_data_b,
    input wire logic          out_is_q_b
);
    logic real_q;
    wire  wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire  rd_go = s_axi_arvalid && s_axi_arready;

    // Decoded address map; the gaps between groups must answer with an error
    function automatic logic known(input logic [5:0] i);
        known = (i inside {[6'h25:6'h27], [6'h2a:6'h2e], [6'h31:6'h35]});
    endfunction
    function automatic logic freq(input logic [5:0] i);
        freq = (i inside {[6'h2a:6'h2d], [6'h31:6'h34]});
    endfunction

    // Mirror of the real-output bit; the bench offers address and data together
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            real_q <= 1'b0;
        else if (wr_go && s_axi_awaddr[AW-1:2] == `DDCM_IDX_DEC_CFG)
            real_q <= s_axi_wdata[`DDCM_BIT_REAL_OUT];
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Two words per sample, then the line falls
    sequence words_a;
        out_valid_a [*2] ##1 !out_valid_a;
    endsequence
    sequence words_b;
        out_valid_b [*2] ##1 !out_valid_b;
    endsequence

    sample_pair_a: assert property (adc_valid |=> words_a and words_b)
        else $error("sample did not give two words");
    iq_alt_a: assert property (adc_valid |=> ##1
        (out_is_q_a != $past(out_is_q_a)) && (out_is_q_b != $past(out_is_q_b)))
        else $error("pair words not one I and one Q");
    read_ans_a: assert property (rd_go |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read answer late or upper bits set");
    rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while one pending");
    write_ans_a: assert property (wr_go |-> ##2 s_axi_bvalid && s_axi_bresp ==
        (known($past(s_axi_awaddr[AW-1:2], 2)) ? `DDCM_RESP_OKAY : `DDCM_RESP_SLVERR))
        else $error("write response wrong");
    bad_read_a: assert property (rd_go && !known(s_axi_araddr[AW-1:2]) |=>
        s_axi_rresp == `DDCM_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    real_freq_a: assert property (rd_go && real_q && freq(s_axi_araddr[AW-1:2]) |=>
        s_axi_rdata == 32'h0000_0000)
        else $error("frequency byte not zero in real mode");
    real_quad_a: assert property (real_q && out_valid_b && out_is_q_b |->
        out_data_b == '0)
        else $error("Q word mixed in real mode");
endmodule // ddcm_checker

bind ddcm_top ddcm_checker #(.DW(DW), .AW(AW)) u_ddcm_checker (
    .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .adc_valid, .out_valid_a, .out_is_q_a, .out_valid_b, .out_data_b, .out_is_q_b
);
`default_nettype wire

// [test/ddcm_top_test.sv]
`include "ddcm_regs.vh"
`default_nettype none
module ddcm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] FA = 32'h1234_5678;
    localparam logic [31:0] FB = 32'h8000_0001;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, adc_valid = 1'b0;
    logic [15:0] adc_a = 16'h0000, adc_b = 16'h0000;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, osc_phase_a, osc_phase_b;
    wire         out_valid_a, out_is_q_a, out_valid_b, out_is_q_b;
    wire  [15:0] out_data_a, out_data_b;
    int          fails = 0, n_checks = 0, cyc = 0;
    logic [31:0] rd_d;
    logic [1:0]  rsp;
    logic [16:0] wa [2], wb [2];    // Captured {is_q, data} per word

    // Only byte lane 0 stores, so the strobe is tied
    ddcm_top #(.DW(16), .AW(8)) u_ddcm_top (
        .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_valid, .adc_a, .adc_b,
        .out_valid_a, .out_data_a, .out_is_q_a, .osc_phase_a, .out_valid_b, .out_data_b,
        .out_is_q_b, .osc_phase_b
    );

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // Hang guard; a full run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results;
        end
    end

    task automatic results;
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Write and read release at the answer edge, then let one edge pass
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [5:0] idx);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    // One sample to both paths; words sampled at the edges that end their cycles
    task automatic smp(input logic [15:0] a, input logic [15:0] b);
        adc_a <= a;
        adc_b <= b;
        adc_valid <= 1'b1;
        @(posedge mclk);
        adc_valid <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            wa[k] = {out_is_q_a, out_data_a};
            wb[k] = {out_is_q_b, out_data_b};
        end
    endtask

    task automatic pair(input logic [16:0] a0, a1, b0, b1);
        check(wa[0], a0);
        check(wa[1], a1);
        check(wb[0], b0);
        check(wb[1], b1);
    endtask

    task automatic t_reg;
        rd(`DDCM_IDX_ORDER_A);
        check(rd_d, 32'h0000_0000);
        wr(`DDCM_IDX_ORDER_A, 8'hff);
        rd(`DDCM_IDX_ORDER_A);
        check(rd_d, 32'h0000_001c);
        wr(`DDCM_IDX_ORDER_A, 8'h00);
    endtask

    task automatic t_swap;
        wr(`DDCM_IDX_ORDER_A, 8'h10);
        wr(`DDCM_IDX_ORDER_B, 8'h10);
        smp(16'h1234, 16'h4321);
        pair({1'b1, 16'h0000}, {1'b0, 16'h1234}, {1'b1, 16'h0000}, {1'b0, 16'h4321});
        wr(`DDCM_IDX_ORDER_A, 8'h00);
        smp(16'h1234, 16'h4321);
        pair({1'b0, 16'h1234}, {1'b1, 16'h0000}, {1'b1, 16'h0000}, {1'b0, 16'h4321});
    endtask

    // Quarter-rate mix with inverted phase, index zeroed by the reload toggle
    task automatic t_mix;
        logic [31:0] mx [4];
        mx = '{32'h0100_0000, 32'h0000_0100, 32'hff00_0000, 32'h0000_ff00};
        wr(`DDCM_IDX_ORDER_A, 8'h04);
        wr(`DDCM_IDX_ORDER_B, 8'h04);
        wr(`DDCM_IDX_MIX_CTRL, 8'h33);
        foreach (mx[k]) begin
            smp(16'h0100, 16'h0100);
            pair({1'b0, mx[k][31:16]}, {1'b1, mx[k][15:0]}, {1'b0, mx[k][31:16]},
                {1'b1, mx[k][15:0]});
        end
        wr(`DDCM_IDX_MIX_CTRL, 8'h22);
        smp(16'h0100, 16'h0100);
        pair({1'b0, 16'h0100}, {1'b1, 16'h0000}, {1'b0, 16'h0100}, {1'b1, 16'h0000});
    endtask

    task automatic t_qdel;
        wr(`DDCM_IDX_ORDER_A, 8'h08);
        wr(`DDCM_IDX_ORDER_B, 8'h08);
        wr(`DDCM_IDX_MIX_CTRL, 8'h11);
        smp(16'h0100, 16'h0100);
        smp(16'h0200, 16'h0200);
        pair({1'b0, 16'h0100}, {1'b1, 16'hfe00}, {1'b0, 16'h0100}, {1'b1, 16'hfe00});
    endtask

    // New word only counts after the reload toggle; toggle restarts the phase
    task automatic t_freq;
        for (int k = 0; k < 4; k++) begin
            wr(6'(`DDCM_IDX_FREQ_A0 + k), FA[8*k +: 8]);
            wr(6'(`DDCM_IDX_FREQ_B0 + k), FB[8*k +: 8]);
            rd(6'(`DDCM_IDX_FREQ_A0 + k));
            check(rd_d, {24'h00_0000, FA[8*k +: 8]});
            rd(6'(`DDCM_IDX_FREQ_B0 + k));
            check(rd_d, {24'h00_0000, FB[8*k +: 8]});
        end
        smp(16'h0001, 16'h0001);
        check(osc_phase_a, 32'h0000_0000);
        wr(`DDCM_IDX_MIX_CTRL, 8'h33);
        repeat (3) smp(16'h0001, 16'h0001);
        check(osc_phase_a, FA * 3);
        check(osc_phase_b, FB * 3);
        // Status shows the top nibbles of both phases: 3 from path A, 8 from path B
        rd(`DDCM_IDX_STATUS);
        check(rd_d, 32'h0000_0038);
        wr(`DDCM_IDX_MIX_CTRL, 8'h11);
        check(osc_phase_a, 32'h0000_0000);
    endtask

    task automatic t_real;
        wr(`DDCM_IDX_DEC_CFG, 8'h08);
        rd(`DDCM_IDX_FREQ_A0);
        check(rd_d, 32'h0000_0000);
        wr(`DDCM_IDX_FREQ_B3, 8'h55);
        rd(`DDCM_IDX_FREQ_B3);
        check(rd_d, 32'h0000_0000);
        // Q-delay is still on, so the second sample shows the first one's I
        repeat (2) smp(16'h0100, 16'h0100);
        pair({1'b0, 16'h0100}, {1'b1, 16'h0000}, {1'b0, 16'h0100}, {1'b1, 16'h0000});
        check(osc_phase_a, 32'h0000_0000);
        check(osc_phase_b, 32'h0000_0000);
        wr(`DDCM_IDX_DEC_CFG, 8'h00);
        rd(`DDCM_IDX_FREQ_A3);
        check(rd_d, 32'h0000_0000);
    endtask

    task automatic t_bad;
        wr(6'h28, 8'h5a);
        check(rsp, `DDCM_RESP_SLVERR);
        rd(6'h2f);
        check(rsp, `DDCM_RESP_SLVERR);
        check(rd_d, 32'h0000_0000);
        wr(`DDCM_IDX_STATUS, 8'h5a);
        check(rsp, `DDCM_RESP_OKAY);
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reg;
        t_swap;
        t_mix;
        t_qdel;
        t_freq;
        t_real;
        t_bad;
        results;
    end
endmodule // ddcm_top_test
`default_nettype wire
